// >>> logic/wwd_pkg.sv
// Purpose: Shared constants and types for the windowed watchdog.
// Assumes: 8-bit register port, 4-bit register index, one core clock.
// Notes:   Offsets and field positions of the config and status registers
//          are local to this block; the counts are counter-clock cycles.
package wwd_pkg;

    // Register port widths
    localparam int ADDR_W = 4;                      // Register index width
    localparam int DATA_W = 8;                      // Register data width
    localparam int CNT_W  = 19;                     // Holds 2^18 inclusive
    localparam int NUM_SLOW_SRC = 3;                // Pin-borne counter clocks

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CFG   = 4'h0;   // watchdog_config_register
    localparam logic [ADDR_W-1:0] ADDR_RSTAT = 4'h1;   // reset_status_register
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 4'h2;   // Watchdog state, read only

    // Config register field positions
    localparam int CFG_TSEL_LSB = 0;                // timeout_select [1:0]
    localparam int CFG_CSEL_LSB = 2;                // counter_clock_select [3:2]
    localparam int CFG_WIN_BIT  = 4;                // window_enable
    localparam int CFG_DBG_BIT  = 5;                // Run in background debug mode

    // Status register field positions
    localparam int STAT_LOCK_BIT  = 0;              // Config has been written
    localparam int STAT_EN_BIT    = 1;              // Watchdog enabled
    localparam int STAT_ARM_BIT   = 2;              // First refresh code seen
    localparam int STAT_WIN_BIT   = 3;              // Refresh window is open

    // Config reset values
    localparam logic [1:0] TSEL_RST = 2'h3;         // Longest timeout
    localparam logic [1:0] CSEL_RST = 2'h0;         // Low-power oscillator
    localparam logic       WIN_RST  = 1'b0;         // Window mode off
    localparam logic       DBG_RST  = 1'b0;         // Halted in debug mode

    // counter_clock_select encodings
    localparam logic [1:0] CSEL_LPO = 2'h0;         // low_power_osc_clock
    localparam logic [1:0] CSEL_BUS = 2'h1;         // system_bus_clock
    localparam logic [1:0] CSEL_IRC = 2'h2;         // internal_rc_clock
    localparam logic [1:0] CSEL_EXT = 2'h3;         // external_osc_clock

    // timeout_select encodings
    localparam logic [1:0] TSEL_OFF   = 2'h0;       // Watchdog disabled
    localparam logic [1:0] TSEL_SHORT = 2'h1;
    localparam logic [1:0] TSEL_MID   = 2'h2;

    // Refresh codes
    localparam logic [DATA_W-1:0] REFRESH_FIRST  = 8'h55;
    localparam logic [DATA_W-1:0] REFRESH_SECOND = 8'haa;

    // Timeout periods in counter-clock cycles
    localparam logic [CNT_W-1:0] SLOW_PERIOD_SHORT = 19'h00020;  // 32
    localparam logic [CNT_W-1:0] SLOW_PERIOD_MID   = 19'h00100;  // 256
    localparam logic [CNT_W-1:0] SLOW_PERIOD_LONG  = 19'h00400;  // 1024
    localparam logic [CNT_W-1:0] FAST_PERIOD_SHORT = 19'h02000;  // 8192
    localparam logic [CNT_W-1:0] FAST_PERIOD_MID   = 19'h10000;  // 65536
    localparam logic [CNT_W-1:0] FAST_PERIOD_LONG  = 19'h40000;  // 262144

    // Refresh sequence tracker
    typedef enum logic {
        SEQ_IDLE,                                   // Waiting for first code
        SEQ_ARMED                                   // First code accepted
    } wwd_seq_type;

endpackage

// >>> logic/wwd_tick_if.sv
// Purpose: Carries synchronised counter-clock ticks to the watchdog core.
// Assumes: Ticks are one core-clock cycle wide.
// Notes:   Bit 0 low-power osc, bit 1 internal RC, bit 2 external clock.
`timescale 1ns/1ps
`default_nettype none
interface wwd_tick_if;
    logic [2:0] tick;                               // One pulse per rising edge

    modport src (output tick);                      // Synchroniser side
    modport dst (input  tick);                      // Counter side
endinterface
`default_nettype wire

// >>> logic/wwd_tick_sync.sv
// Purpose: Brings the slow counter clocks into the core clock domain.
// Assumes: Each slow clock is well below half the core clock rate.
// Notes:   Two flops then an edge detector per source; the first flop
//          feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_sync
    import wwd_pkg::*;
(
    input  wire logic                    core_clk,  // Core clock
    input  wire logic                    rst,       // Async reset, high
    input  wire logic [NUM_SLOW_SRC-1:0] slowClk,   // Raw slow clock pins
    wwd_tick_if.src                      ticks      // Edge pulses out
);

    genvar g;
    generate
        for (g = 0; g < NUM_SLOW_SRC; g++) begin : gen_src
            logic meta_q;                           // First stage, metastable
            logic sync_q;                           // Second stage, stable
            logic prev_q;                           // Delayed copy for edge

            // Synchroniser chain and edge history
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= slowClk[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            // Rising edge of the settled level only
            assign ticks.tick[g] = sync_q & ~prev_q;
        end
    endgenerate

endmodule
`default_nettype wire

// >>> logic/wwd_windowed_watchdog.sv
// Purpose: Windowed watchdog with write-once configuration and refresh
//          code checking, raising one reset request to the system.
// Assumes: Register strobes come from logic on core_clk; mode inputs are
//          synchronous; slow clock pins are asynchronous.
// Notes:   The reset request stays high until rst, since the system reset
//          that it triggers also resets this block.
//
// Contract
// - Enabled after reset; timeout select 00 disables.
// - Writing 0x55 then 0xAA restarts the period.
// - Refresh writes never change reset status reads.
// - Counter reaching timeout period requests system reset.
// - Any other value written requests immediate reset.
// - Window mode: refresh only in final quarter.
// - Refresh before window opens requests immediate reset.
// - Window mode only with bus clock selected.
// - Configuration accepts only first write after reset.
// - Counter cleared by reset and first config write.
// - Clock select picks one of four counter clocks.
// - Slow clocks time out after 32/256/1024 cycles.
// - Fast clocks: 8192/65536/262144; window at three quarters.
// - Reset default: low-power oscillator, longest timeout.
// - Bus clock: counter holds in debug or stop.
// - Other clocks: counter zeroed in debug or stop.
// - Not counting in background debug unless configured.
`timescale 1ns/1ps
`default_nettype none
module wwd_windowed_watchdog
    import wwd_pkg::*;
#(
    parameter logic [CNT_W-1:0] FAST_SHORT = FAST_PERIOD_SHORT,  // 8192 cycles
    parameter logic [CNT_W-1:0] FAST_MID   = FAST_PERIOD_MID,    // 65536 cycles
    parameter logic [CNT_W-1:0] FAST_LONG  = FAST_PERIOD_LONG    // 262144 cycles
) (
    input  wire logic              core_clk,       // Core clock, 50 MHz
    input  wire logic              rst,            // Async reset, high
    input  wire logic [ADDR_W-1:0] regAddr,        // Register index
    input  wire logic [DATA_W-1:0] regWrData,      // Write data
    input  wire logic              regWrStb,       // Write strobe
    input  wire logic              regRdStb,       // Read strobe
    output var  logic [DATA_W-1:0] regRdData,      // Read data, one cycle later
    input  wire logic [DATA_W-1:0] resetStatusIn,  // Contents of reset status
    input  wire logic              low_power_osc_clock,         // low_power_osc_clock pin
    input  wire logic              ircClk,         // internal_rc_clock pin
    input  wire logic              external_osc_clock,         // external_osc_clock pin
    input  wire logic              debugMode,      // background_debug_mode active
    input  wire logic              stopMode,       // Device in stop mode
    output var  logic              resetReq        // System reset request
);

    // Configuration state
    logic [1:0]        tsel_q;                     // timeout_select
    logic [1:0]        csel_q;                     // counter_clock_select
    logic              winEn_q;                    // window_enable
    logic              dbgRun_q;                   // Count in debug mode
    logic              locked_q;                   // Config write seen

    // Counter and sequence state
    logic [CNT_W-1:0]  count_q;                    // Counter value
    logic [CNT_W-1:0]  count_d;                    // Next counter value
    wwd_seq_type       seq_q;                      // Refresh tracker
    wwd_seq_type       seq_d;                      // Next tracker state
    logic              resetReq_q;                 // Sticky reset request
    logic [DATA_W-1:0] rdData_q;                   // Registered read data
    logic [DATA_W-1:0] rdMux;                      // Selected read value

    // Decoded strobes
    wire               cfgWrite;                   // Write to config reg
    wire               cfgFirst;                   // Write that locks config
    wire               rsWrite;                    // Write to reset status reg
    wire               isFirstCode;                // Data is 0x55
    wire               isSecondCode;               // Data is 0xaa

    // Counting control
    wire               enabled;                    // Watchdog active
    wire               busSel;                     // Bus clock selected
    wire               winMode;                    // Window mode in force
    wire               haltNow;                    // Debug or stop halts count
    wire               tickSel;                    // Tick of chosen clock
    wire [CNT_W-1:0]   period;                     // Selected timeout period
    wire [CNT_W-1:0]   lastCount;                  // Count at which it expires
    wire [CNT_W-1:0]   winStart;                   // Count at which window opens
    wire               windowOpen;                 // Refresh currently allowed

    // Reset causes
    wire               timeoutHit;                 // Period expired
    wire               badCode;                    // Wrong value written
    wire               earlyRefresh;               // Refresh before window
    wire               refreshDone;                // Valid 0x55, 0xaa pair

    // Slow clock ticks from the synchroniser
    wwd_tick_if ticks ();

    // Synchronises the three pin-borne counter clocks
    wwd_tick_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .slowClk  ({external_osc_clock, ircClk, low_power_osc_clock}),
        .ticks    (ticks.src)
    );

    // Timeout period for a clock and timeout selection
    function automatic logic [CNT_W-1:0] periodOf(input logic [1:0] csel,
                                                  input logic [1:0] tsel);
        logic fast;
        fast = (csel == CSEL_BUS) || (csel == CSEL_EXT);
        if (tsel == TSEL_SHORT) begin
            periodOf = fast ? FAST_SHORT : SLOW_PERIOD_SHORT;
        end else if (tsel == TSEL_MID) begin
            periodOf = fast ? FAST_MID : SLOW_PERIOD_MID;
        end else begin
            periodOf = fast ? FAST_LONG : SLOW_PERIOD_LONG;
        end
    endfunction

    // Counter clock chosen by the clock select field
    function automatic logic tickOf(input logic [1:0] csel,
                                    input logic [2:0] slowTick);
        if (csel == CSEL_BUS) begin
            tickOf = 1'b1;                          // Every core clock
        end else if (csel == CSEL_LPO) begin
            tickOf = slowTick[0];
        end else if (csel == CSEL_IRC) begin
            tickOf = slowTick[1];
        end else begin
            tickOf = slowTick[2];
        end
    endfunction

    // Register strobe decoding
    assign cfgWrite     = regWrStb && (regAddr == ADDR_CFG);
    assign cfgFirst     = cfgWrite && !locked_q;
    assign rsWrite      = regWrStb && (regAddr == ADDR_RSTAT);
    assign isFirstCode  = (regWrData == REFRESH_FIRST);
    assign isSecondCode = (regWrData == REFRESH_SECOND);

    // Enable and mode decoding
    assign enabled  = (tsel_q != TSEL_OFF);
    assign busSel   = (csel_q == CSEL_BUS);
    assign winMode  = winEn_q && busSel;
    assign haltNow  = stopMode || (debugMode && !dbgRun_q);
    assign tickSel  = tickOf(csel_q, ticks.tick);

    // Period and window thresholds; the window is the final quarter
    assign period     = periodOf(csel_q, tsel_q);
    assign lastCount  = period - 19'h00001;
    assign winStart   = period - (period >> 2);
    assign windowOpen = !winMode || (count_q >= winStart);

    // Reset causes; a disabled watchdog raises none of them
    assign timeoutHit   = enabled && !haltNow && tickSel
                          && (count_q == lastCount);
    assign badCode      = enabled && rsWrite
                          && !isFirstCode && !isSecondCode;
    assign earlyRefresh = enabled && rsWrite && !windowOpen
                          && (isFirstCode || isSecondCode);
    assign refreshDone  = enabled && rsWrite && windowOpen
                          && isSecondCode && (seq_q == SEQ_ARMED);

    // Configuration register: written once, then frozen until reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tsel_q   <= TSEL_RST;
            csel_q   <= CSEL_RST;
            winEn_q  <= WIN_RST;
            dbgRun_q <= DBG_RST;
            locked_q <= 1'b0;
        end else if (cfgFirst) begin
            tsel_q   <= regWrData[CFG_TSEL_LSB +: 2];
            csel_q   <= regWrData[CFG_CSEL_LSB +: 2];
            winEn_q  <= regWrData[CFG_WIN_BIT];
            dbgRun_q <= regWrData[CFG_DBG_BIT];
            locked_q <= 1'b1;
        end
    end

    // Next counter value; cleared on refresh or the locking config write
    always_comb begin
        count_d = count_q;
        if (cfgFirst || refreshDone) begin
            count_d = '0;
        end else if (!enabled) begin
            count_d = '0;
        end else if (haltNow) begin
            if (busSel) begin
                count_d = count_q;
            end else begin
                count_d = '0;
            end
        end else if (timeoutHit) begin
            count_d = '0;                   // Request is already raised
        end else if (tickSel) begin
            count_d = count_q + 19'h00001;
        end
    end

    // Refresh tracker: any other write to the status address returns it to idle
    always_comb begin
        seq_d = seq_q;
        if (rsWrite) begin
            if (isFirstCode && windowOpen) begin
                seq_d = SEQ_ARMED;
            end else begin
                seq_d = SEQ_IDLE;
            end
        end
    end

    // Counter and tracker
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_q  <= '0;
            seq_q    <= SEQ_IDLE;
        end else begin
            count_q  <= count_d;
            seq_q    <= seq_d;
        end
    end

    // One sticky request for every cause; only rst takes it away
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resetReq_q <= 1'b0;
        end else if (timeoutHit || badCode || earlyRefresh) begin
            resetReq_q <= 1'b1;
        end
    end

    // Read selection; the reset status contents come from outside
    always_comb begin
        rdMux = '0;
        if (regAddr == ADDR_CFG) begin
            rdMux[CFG_TSEL_LSB +: 2] = tsel_q;
            rdMux[CFG_CSEL_LSB +: 2] = csel_q;
            rdMux[CFG_WIN_BIT]       = winEn_q;
            rdMux[CFG_DBG_BIT]       = dbgRun_q;
        end else if (regAddr == ADDR_RSTAT) begin
            rdMux = resetStatusIn;
        end else if (regAddr == ADDR_STAT) begin
            rdMux[STAT_LOCK_BIT] = locked_q;
            rdMux[STAT_EN_BIT]   = enabled;
            rdMux[STAT_ARM_BIT]  = (seq_q == SEQ_ARMED);
            rdMux[STAT_WIN_BIT]  = windowOpen && enabled;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_q <= '0;
        end else if (regRdStb) begin
            rdData_q <= rdMux;
        end else begin
            rdData_q <= '0;
        end
    end

    // Outputs come straight from flops
    assign regRdData = rdData_q;
    assign resetReq  = resetReq_q;

endmodule
`default_nettype wire

// >>> sim/wwd_sys_model.sv
// Purpose: Free-running slow oscillators feeding the watchdog clock pins.
// Assumes: Oscillators run regardless of core activity.
// Notes:   Periods sit near eight core cycles and drift against core_clk.
`timescale 1ns/1ps
`default_nettype none
module wwd_sys_model (
    output var logic low_power_osc_clock, // Low-power oscillator
    output var logic ircClk, // Internal RC oscillator
    output var logic external_osc_clock  // External oscillator
);
    // Odd half periods wander over the core clock phase
    initial begin
        low_power_osc_clock = 1'b0;
        ircClk = 1'b1;
        external_osc_clock = 1'b0;
    end
    always #83 low_power_osc_clock = ~low_power_osc_clock;
    always #79 ircClk = ~ircClk;
    always #91 external_osc_clock = ~external_osc_clock;
endmodule
`default_nettype wire

// >>> sim/wwd_windowed_watchdog_chk.sv
// Purpose: Concurrent checks on the watchdog top-level ports.
// Assumes: Bus-clock counting is mirrored here; slow clocks are not.
// Notes:   The shadow counter is trusted only when the bus clock is selected.
`timescale 1ns/1ps
`default_nettype none
module wwd_windowed_watchdog_chk
    import wwd_pkg::*;
#(
    parameter logic [CNT_W-1:0] FAST_SHORT = FAST_PERIOD_SHORT, // Short period
    parameter logic [CNT_W-1:0] FAST_MID   = FAST_PERIOD_MID,   // Middle period
    parameter logic [CNT_W-1:0] FAST_LONG  = FAST_PERIOD_LONG   // Long period
) (
    input wire logic              core_clk,      // Core clock
    input wire logic              rst,           // Async reset
    input wire logic [ADDR_W-1:0] regAddr,       // Register index
    input wire logic [DATA_W-1:0] regWrData,     // Write data
    input wire logic              regWrStb,      // Write strobe
    input wire logic              regRdStb,      // Read strobe
    input wire logic [DATA_W-1:0] regRdData,     // Read data
    input wire logic [DATA_W-1:0] resetStatusIn, // Status contents
    input wire logic              debugMode,     // Debug mode
    input wire logic              stopMode,      // Stop mode
    input wire logic              resetReq       // Reset request
);
    logic             lockQ;  // Config already written
    logic [5:0]       cfgQ;   // Shadow of config fields
    logic             armQ;   // First refresh code seen
    logic [CNT_W-1:0] cntQ;   // Shadow bus-clock count
    wire              cfgWr  = regWrStb && regAddr == ADDR_CFG && !lockQ;
    wire              rsWr   = regWrStb && regAddr == ADDR_RSTAT;
    wire              isCode = regWrData == REFRESH_FIRST || regWrData == REFRESH_SECOND;
    wire              en     = cfgQ[1:0] != TSEL_OFF;
    wire              bus    = cfgQ[3:2] == CSEL_BUS;
    wire              halt   = stopMode || (debugMode && !cfgQ[CFG_DBG_BIT]);
    wire [CNT_W-1:0]  period = cfgQ[1:0] == TSEL_SHORT ? FAST_SHORT :
                               cfgQ[1:0] == TSEL_MID ? FAST_MID : FAST_LONG;
    wire              early  = bus && cfgQ[CFG_WIN_BIT] && cntQ < period - (period >> 2);
    wire              done   = rsWr && armQ && regWrData == REFRESH_SECOND && !early;

    // Mirror of the counter; a completed pair or the locking config write restarts it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lockQ <= 1'b0;
            cfgQ  <= {DBG_RST, WIN_RST, CSEL_RST, TSEL_RST};
            armQ  <= 1'b0;
            cntQ  <= '0;
        end else begin
            if (cfgWr) begin
                lockQ <= 1'b1;
                cfgQ  <= regWrData[5:0];
            end
            if (rsWr) begin
                armQ <= regWrData == REFRESH_FIRST && !early;
            end
            if (cfgWr || done) begin
                cntQ <= '0;
            end else if (!halt) begin
                cntQ <= cntQ + 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    status_read_a: assert property ($past(regRdStb) && $past(regAddr) == ADDR_RSTAT |->
        regRdData == $past(resetStatusIn)) else $error("status read differs from input");
    cfg_read_a: assert property ($past(regRdStb) && $past(regAddr) == ADDR_CFG |->
        regRdData[5:0] == $past(cfgQ)) else $error("config read differs from first write");
    req_hold_a: assert property (resetReq |=> resetReq)
        else $error("reset request dropped");
    bad_code_a: assert property (rsWr && !isCode && en |=> resetReq)
        else $error("bad code gave no reset request");
    early_write_a: assert property (rsWr && isCode && early && en |=> resetReq)
        else $error("early refresh gave no reset request");
    bus_timeout_a: assert property (lockQ && bus && en && !halt && !done &&
        cntQ == period - 1'b1 |=> resetReq) else $error("timeout gave no reset request");
    off_quiet_a: assert property (lockQ && !en |=> !$rose(resetReq))
        else $error("disabled watchdog requested reset");
    window_ok_a: assert property (rsWr && isCode && !early && en && !resetReq &&
        cntQ < period - 1'b1 |=> !resetReq) else $error("refresh in window caused reset");

    cover property (done);
    cover property (rsWr && early && en);
    cover property (lockQ && bus && halt && en);
endmodule

bind wwd_windowed_watchdog wwd_windowed_watchdog_chk #(
    .FAST_SHORT(FAST_SHORT), .FAST_MID(FAST_MID), .FAST_LONG(FAST_LONG)
) u_chk (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .resetStatusIn(resetStatusIn),
    .debugMode(debugMode), .stopMode(stopMode), .resetReq(resetReq)
);
`default_nettype wire

// >>> sim/wwd_windowed_watchdog_tb.sv
// Purpose: Self-checking bench for the windowed watchdog.
// Assumes: Short fast periods of 16/32/64 cycles.
// Notes:   Driver queues expected reads and reset requests; monitor pops them.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module wwd_windowed_watchdog_tb
    import wwd_pkg::*;
;
    localparam logic [CNT_W-1:0] PS = 19'h00010; // Short bus period
    logic              core_clk = 1'b0; // Core clock
    logic              rst      = 1'b1; // Reset
    logic [ADDR_W-1:0] regAddr;         // Register index
    logic [DATA_W-1:0] regWrData;       // Write data
    logic              regWrStb = 1'b0; // Write strobe
    logic              regRdStb = 1'b0; // Read strobe
    logic [DATA_W-1:0] resetStatusIn;   // Status contents
    logic              debugMode;       // Debug mode
    logic              stopMode;        // Stop mode
    logic [DATA_W-1:0] regRdData;       // Read data
    logic              resetReq;        // Reset request
    logic              low_power_osc_clock, ircClk, external_osc_clock; // Slow clocks
    int                fails   = 0;     // Mismatches
    int                n_tests = 0;     // Comparisons
    logic [8:0]        expQ[$];         // Bit 8 marks a reset event
    logic [8:0]        e;               // Popped note
    logic              rdPend  = 1'b0;  // Read data due now
    logic              reqPrev = 1'b0;  // Request last cycle
    int                p;               // Period in use
    logic [7:0]        bad;             // Random bad code

    always #10 core_clk = ~core_clk;

    wwd_windowed_watchdog #(.FAST_SHORT(PS), .FAST_MID(19'h00020), .FAST_LONG(19'h00040)) u_dut (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .resetStatusIn(resetStatusIn), .low_power_osc_clock(low_power_osc_clock), .ircClk(ircClk), .external_osc_clock(external_osc_clock),
        .debugMode(debugMode), .stopMode(stopMode), .resetReq(resetReq));
    wwd_sys_model u_sys (.low_power_osc_clock(low_power_osc_clock), .ircClk(ircClk), .external_osc_clock(external_osc_clock));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One strobe edge, then one idle edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        tick(1);
        regWrStb <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        regAddr <= a;
        regRdStb <= 1'b1;
        tick(1);
        regRdStb <= 1'b0;
        expQ.push_back({1'b0, x});
        tick(1);
    endtask
    task automatic doReset();
        rst <= 1'b1;
        debugMode <= 1'b0;
        stopMode <= 1'b0;
        resetStatusIn <= 8'($urandom);
        tick(3);
        rst <= 1'b0;
        tick(1);
    endtask
    task automatic endTest(input string nm);
        `CHK("pending notes", 0, expQ.size())
        $display("test %s done", nm);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Monitor: each read answer or rising request pops one note
    always @(posedge core_clk) begin
        if (rdPend || (resetReq && !reqPrev)) begin
            if (expQ.size() == 0) `CHK("unexpected output", 1'b1, 1'b0)
            else begin
                e = expQ.pop_front();
                `CHK("output", e, {!rdPend, rdPend ? regRdData : 8'h00})
            end
        end
        rdPend = regRdStb;
        reqPrev = resetReq;
    end

    initial begin
        #(20ns * 40000);
        fails++;
        final_report();
    end

    initial begin
        void'($urandom(22389));
        doReset();
        rd(ADDR_CFG, 8'h03);
        rd(ADDR_STAT, 8'h0a);
        rd(ADDR_RSTAT, resetStatusIn);
        rd(4'h9, 8'h00);
        wr(ADDR_RSTAT, REFRESH_FIRST);
        wr(ADDR_RSTAT, REFRESH_SECOND);
        rd(ADDR_RSTAT, resetStatusIn);
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_CFG, 8'h03);
        rd(ADDR_CFG, 8'h00);
        wr(ADDR_RSTAT, 8'h12);
        tick(20);
        endTest("defaults");
        for (int t = 1; t < 4; t++) begin
            doReset();
            p = 8 << t;
            wr(ADDR_CFG, {4'h0, CSEL_BUS, 2'(t)});
            tick(p - 2);
            expQ.push_back(9'h100);
            tick(4);
        end
        endTest("bus timeouts");
        doReset();
        do bad = 8'($urandom); while (bad == REFRESH_FIRST || bad == REFRESH_SECOND);
        wr(ADDR_RSTAT, REFRESH_FIRST);
        expQ.push_back(9'h100);
        wr(ADDR_RSTAT, bad);
        tick(3);
        endTest("bad code");
        doReset();
        wr(ADDR_CFG, 8'h05);
        tick(8);
        wr(ADDR_RSTAT, REFRESH_FIRST);
        wr(ADDR_RSTAT, REFRESH_SECOND);
        tick(4);
        wr(ADDR_CFG, 8'h03);
        tick(PS - 8);
        expQ.push_back(9'h100);
        tick(4);
        endTest("refresh");
        doReset();
        wr(ADDR_CFG, 8'h15);
        tick(11);
        wr(ADDR_RSTAT, REFRESH_FIRST);
        wr(ADDR_RSTAT, REFRESH_SECOND);
        expQ.push_back(9'h100);
        wr(ADDR_RSTAT, REFRESH_FIRST);
        tick(3);
        endTest("window");
        doReset();
        wr(ADDR_CFG, 8'h05);
        tick(4);
        debugMode <= 1'b1;
        tick(15);
        debugMode <= 1'b0;
        stopMode <= 1'b1;
        tick(15);
        stopMode <= 1'b0;
        tick(10);
        expQ.push_back(9'h100);
        tick(4);
        doReset();
        wr(ADDR_CFG, 8'h25);
        debugMode <= 1'b1;
        tick(PS - 2);
        expQ.push_back(9'h100);
        tick(4);
        endTest("halts");
        for (int c = 0; c < 4; c++) begin
            if (c == 1) continue;
            doReset();
            p = (c == 3) ? 16 : 32;
            wr(ADDR_CFG, {2'h0, 1'b0, 1'b1, 2'(c), 2'h1});
            wr(ADDR_RSTAT, REFRESH_FIRST);
            wr(ADDR_RSTAT, REFRESH_SECOND);
            tick((p - 3) * 7);
            expQ.push_back(9'h100);
            tick(p * 4 + 20);
        end
        endTest("slow clocks");
        final_report();
    end
endmodule
`default_nettype wire
